/* File: core/onoff_regs.sv */
// on/off control, write protection and vout format register bank
module onoff_regs
(
    input  wire logic                       i_clk,                 // core clock, 25 MHz
    input  wire logic                       i_rstn,                // async reset, active low
    input  wire onoff_regs_pkg::cmd_req_s   i_req,                 // host command
    input  wire logic                       i_power_present,       // input power good
    input  wire logic                       i_power_supply_on_pin, // on/off pin, async
    output logic                            o_rsp_valid,           // answer strobe
    output logic                            o_rsp_ack,             // command accepted
    output logic [15:0]                     o_rsp_rdata,           // read data
    output onoff_regs_pkg::action_s         o_action,              // send-byte pulses
    output logic                            o_run,                 // converter enable
    output logic [2:0]                      o_vout_exponent,       // exponent n
    output logic [11:0]                     o_vout_mantissa        // setpoint mantissa
);
    import onoff_regs_pkg::*;

    typedef struct packed {
        logic        pin_meta;
        logic        pin_sync;
        logic [7:0]  run_cmd;
        logic [7:0]  cfg;
        logic [7:0]  lock;
        logic [7:0]  vfmt;
        logic [15:0] vset;
        cmd_rsp_s    rsp;
        action_s     act;
        logic        run;
    } state_s;

    state_s state_reg;
    state_s state_next;

    logic        wr_allowed;
    logic        code_known;
    logic        pin_asserted;
    logic        cmd_ok;
    logic        pin_ok;
    logic        is_wr;
    logic [15:0] rd_val;

    // ==========================================================
    // write protection
    always_comb
    begin
        // strictest lock checked first
        if (state_reg.lock[LOCK_ALL_BIT])
        begin
            wr_allowed = (i_req.code == CMD_WRITE_LOCK);
        end
        else if (state_reg.lock[LOCK_RUN_BIT])
        begin
            wr_allowed = (i_req.code == CMD_WRITE_LOCK)
                       || (i_req.code == CMD_RUN_COMMAND)
                       || (i_req.code == CMD_EEPROM_PAGE_ERASE);
        end
        else if (state_reg.lock[LOCK_CFG_BIT])
        begin
            wr_allowed = (i_req.code == CMD_WRITE_LOCK)
                       || (i_req.code == CMD_RUN_COMMAND)
                       || (i_req.code == CMD_EEPROM_PAGE_ERASE)
                       || (i_req.code == CMD_ONOFF_CONFIG)
                       || (i_req.code == CMD_VOUT_SETPOINT);
        end
        else
        begin
            wr_allowed = 1'b1;
        end
    end

    // ==========================================================
    // read decode, address equals command code
    always_comb
    begin
        code_known = 1'b1;
        rd_val     = 16'h0000;
        case (i_req.code)
            CMD_RUN_COMMAND:     rd_val = {8'h00, state_reg.run_cmd};
            CMD_ONOFF_CONFIG:    rd_val = {8'h00, state_reg.cfg};
            CMD_WRITE_LOCK:      rd_val = {8'h00, state_reg.lock};
            CMD_CAPABILITY:      rd_val = {8'h00, CAPABILITY_VAL};
            CMD_VOUT_FORMAT_EXP: rd_val = {8'h00, state_reg.vfmt};
            CMD_VOUT_SETPOINT:   rd_val = state_reg.vset;
            default:             code_known = 1'b0;
        endcase
    end

    assign pin_asserted = state_reg.cfg[CFG_POLARITY_BIT]
                        ? state_reg.pin_sync : ~state_reg.pin_sync;
    assign pin_ok = ~state_reg.cfg[CFG_PIN_GATE_BIT] || pin_asserted;
    assign cmd_ok = ~state_reg.cfg[CFG_CMD_GATE_BIT]
                  || state_reg.run_cmd[RUN_ENABLE_BIT];
    assign is_wr  = i_req.valid && i_req.write && !i_req.send;

    // ==========================================================
    // next state
    always_comb
    begin
        state_next          = state_reg;
        state_next.pin_meta = i_power_supply_on_pin;
        state_next.pin_sync = state_reg.pin_meta;
        state_next.rsp      = '0;
        state_next.act      = '0;

        if (i_req.valid)
        begin
            state_next.rsp.valid = 1'b1;
            if (i_req.send)
            begin
                state_next.rsp.ack = 1'b1;
                case (i_req.code)
                    CMD_CLEAR_FAULTS:    state_next.act.clear_faults    = 1'b1;
                    CMD_RESTORE_DEFAULT: state_next.act.restore_default = 1'b1;
                    CMD_STORE_USER:      state_next.act.store_user      = 1'b1;
                    CMD_RESTORE_USER:    state_next.act.restore_user    = 1'b1;
                    default:             state_next.rsp.ack             = 1'b0;
                endcase
            end
            else if (!i_req.write)
            begin
                state_next.rsp.ack   = code_known;
                state_next.rsp.rdata = rd_val;
            end
            else
            begin
                state_next.rsp.ack = code_known && wr_allowed
                                   && (i_req.code != CMD_CAPABILITY);
            end
        end

        // blocked writes fall through untouched
        if (is_wr && wr_allowed)
        begin
            case (i_req.code)
                CMD_RUN_COMMAND:
                    state_next.run_cmd = (i_req.wdata[7:0] & 8'h80)
                                       | RUN_FIXED_VAL;
                CMD_ONOFF_CONFIG:
                    state_next.cfg = (i_req.wdata[7:0] & CFG_WR_MASK)
                                   | CFG_FIXED_VAL;
                CMD_WRITE_LOCK:
                    state_next.lock = i_req.wdata[7:0] & LOCK_WR_MASK;
                CMD_VOUT_FORMAT_EXP:
                    state_next.vfmt = i_req.wdata[7:0] & VFMT_WR_MASK;
                CMD_VOUT_SETPOINT:
                    state_next.vset = i_req.wdata & VSET_WR_MASK;
                default:
                    state_next.vset = state_reg.vset;
            endcase
        end

        // start condition; power loss drops run on the next edge, an off command one edge later, the pin two edges later
        if (!i_power_present)
        begin
            state_next.run = 1'b0;
        end
        else if (state_reg.cfg[CFG_POWERUP_BIT])
        begin
            state_next.run = pin_ok && cmd_ok;
        end
        else
        begin
            state_next.run = 1'b1;
        end
    end

    // ==========================================================
    // state register
    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            state_reg         <= '0;
            state_reg.run_cmd <= RUN_RESET;
            state_reg.cfg     <= CFG_RESET;
            state_reg.lock    <= LOCK_RESET;
            state_reg.vfmt    <= VFMT_RESET;
            state_reg.vset    <= VSET_RESET;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    assign o_rsp_valid     = state_reg.rsp.valid;
    assign o_rsp_ack       = state_reg.rsp.ack;
    assign o_rsp_rdata     = state_reg.rsp.rdata;
    assign o_action        = state_reg.act;
    assign o_run           = state_reg.run;
    assign o_vout_exponent = state_reg.vfmt[2:0];
    assign o_vout_mantissa = state_reg.vset[11:0];

endmodule

/* File: core/onoff_regs_pkg.sv */
// package: command codes, field layouts and fixed values of the on/off register bank
package onoff_regs_pkg;

    // command codes double as register addresses
    localparam logic [7:0] CMD_RUN_COMMAND      = 8'h01;
    localparam logic [7:0] CMD_ONOFF_CONFIG     = 8'h02;
    localparam logic [7:0] CMD_CLEAR_FAULTS     = 8'h03;
    localparam logic [7:0] CMD_WRITE_LOCK       = 8'h10;
    localparam logic [7:0] CMD_RESTORE_DEFAULT  = 8'h12;
    localparam logic [7:0] CMD_STORE_USER       = 8'h15;
    localparam logic [7:0] CMD_RESTORE_USER     = 8'h16;
    localparam logic [7:0] CMD_CAPABILITY       = 8'h19;
    localparam logic [7:0] CMD_VOUT_FORMAT_EXP  = 8'h20;
    localparam logic [7:0] CMD_VOUT_SETPOINT    = 8'h21;
    localparam logic [7:0] CMD_EEPROM_PAGE_ERASE = 8'hd4;

    // run_command fields
    localparam int RUN_ENABLE_BIT = 7;
    localparam logic [7:0] RUN_FIXED_MASK = 8'h3c;
    localparam logic [7:0] RUN_FIXED_VAL  = 8'h04;  // margin 00, fault reaction 01
    localparam logic [7:0] RUN_RESET      = 8'h04;

    // onoff_config fields
    localparam int CFG_POWERUP_BIT  = 4;
    localparam int CFG_CMD_GATE_BIT = 3;
    localparam int CFG_PIN_GATE_BIT = 2;
    localparam int CFG_POLARITY_BIT = 1;
    localparam logic [7:0] CFG_WR_MASK   = 8'h1e;
    localparam logic [7:0] CFG_FIXED_VAL = 8'h01;
    localparam logic [7:0] CFG_RESET     = 8'h01;

    // write_lock fields
    localparam int LOCK_ALL_BIT   = 7;
    localparam int LOCK_RUN_BIT   = 6;
    localparam int LOCK_CFG_BIT   = 5;
    localparam logic [7:0] LOCK_WR_MASK = 8'he0;
    localparam logic [7:0] LOCK_RESET   = 8'h00;

    // feature_capability: no pec, 400 khz, no alert
    localparam logic [7:0] CAPABILITY_VAL = 8'h20;

    // vout_format_exponent: linear mode 000, exponent in [2:0]
    localparam logic [7:0] VFMT_WR_MASK = 8'h07;
    localparam logic [7:0] VFMT_RESET   = 8'h00;

    // vout_setpoint: 12-bit mantissa
    localparam logic [15:0] VSET_WR_MASK = 16'h0fff;
    localparam logic [15:0] VSET_RESET   = 16'h0000;

    // host command port
    typedef struct packed {
        logic        valid;
        logic        write;   // 0 = read
        logic        send;    // send-byte, no data
        logic [7:0]  code;
        logic [15:0] wdata;
    } cmd_req_s;

    typedef struct packed {
        logic        valid;
        logic        ack;     // 0 = refused or unmapped
        logic [15:0] rdata;
    } cmd_rsp_s;

    // one-cycle action pulses towards the rest of the device
    typedef struct packed {
        logic clear_faults;
        logic restore_default;
        logic store_user;
        logic restore_user;
    } action_s;

endpackage

/* File: tb/onoff_regs_chk.sv */
// checker: port-level properties of the on/off register bank
module onoff_regs_chk
(
    input  wire logic                     i_clk,                 // clock
    input  wire logic                     i_rstn,                // reset
    input  wire onoff_regs_pkg::cmd_req_s i_req,                 // request
    input  wire logic                     i_power_present,       // power
    input  wire logic                     i_power_supply_on_pin, // pin
    input  wire logic                     o_rsp_valid,           // answer
    input  wire logic                     o_rsp_ack,             // accepted
    input  wire logic [15:0]              o_rsp_rdata,           // data
    input  wire onoff_regs_pkg::action_s  o_action,              // pulses
    input  wire logic                     o_run,                 // enable
    input  wire logic [2:0]               o_vout_exponent,       // exponent
    input  wire logic [11:0]              o_vout_mantissa        // mantissa
);
    import onoff_regs_pkg::*;
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rstn);
    sequence s_rd(logic [7:0] c);
        i_req.valid && !i_req.write && !i_req.send && i_req.code == c;
    endsequence
    sequence s_snd(logic [7:0] c);
        i_req.valid && i_req.send && i_req.code == c;
    endsequence
    property p_run_rd;
        s_rd(8'h01) |=> o_rsp_ack && o_rsp_rdata[15:8] == 8'h00 && o_rsp_rdata[6:0] == 7'h04;
    endproperty
    property p_cfg_rd;
        s_rd(8'h02) |=> o_rsp_ack && o_rsp_rdata[0];
    endproperty
    property p_cap_rd;
        s_rd(8'h19) |=> o_rsp_ack && o_rsp_rdata[7:4] == 4'h2;
    endproperty
    property p_cap_wr;
        i_req.valid && i_req.write && !i_req.send && i_req.code == 8'h19 |=> !o_rsp_ack;
    endproperty
    property p_vfmt_rd;
        s_rd(8'h20) |=> o_rsp_rdata[7:5] == 3'h0 && o_rsp_rdata[2:0] == o_vout_exponent;
    endproperty
    property p_vset_rd;
        s_rd(8'h21) |=> o_rsp_rdata[15:12] == 4'h0 && o_rsp_rdata[11:0] == o_vout_mantissa;
    endproperty
    property p_clear;
        s_snd(8'h03) |=> o_rsp_ack && o_action == 4'h8;
    endproperty
    property p_dflt;
        s_snd(8'h12) |=> o_action.restore_default;
    endproperty
    property p_store;
        s_snd(8'h15) |=> o_action.store_user;
    endproperty
    property p_user;
        s_snd(8'h16) |=> o_action.restore_user;
    endproperty
    property p_off;
        !i_power_present |=> !o_run;
    endproperty
    a_run_rd: assert property (p_run_rd) else $error("run_command fixed bits");
    a_cfg_rd: assert property (p_cfg_rd) else $error("config bit 0");
    a_cap_rd: assert property (p_cap_rd) else $error("capability bits");
    a_cap_wr: assert property (p_cap_wr) else $error("capability written");
    a_vfmt_rd: assert property (p_vfmt_rd) else $error("vout format");
    a_vset_rd: assert property (p_vset_rd) else $error("vout setpoint");
    a_clear: assert property (p_clear) else $error("clear pulse");
    a_dflt: assert property (p_dflt) else $error("default pulse");
    a_store: assert property (p_store) else $error("store pulse");
    a_user: assert property (p_user) else $error("user pulse");
    a_off: assert property (p_off) else $error("run without power");
endmodule

bind onoff_regs onoff_regs_chk u_chk (.i_clk(i_clk), .i_rstn(i_rstn), .i_req(i_req),
    .i_power_present(i_power_present), .i_power_supply_on_pin(i_power_supply_on_pin),
    .o_rsp_valid(o_rsp_valid), .o_rsp_ack(o_rsp_ack), .o_rsp_rdata(o_rsp_rdata),
    .o_action(o_action), .o_run(o_run), .o_vout_exponent(o_vout_exponent),
    .o_vout_mantissa(o_vout_mantissa));

/* File: tb/host_model.sv */
// partner: host side of the command port
module host_model
(
    input  wire logic                i_clk,       // clock
    input  wire logic                i_rsp_valid, // answer strobe
    output onoff_regs_pkg::cmd_req_s o_req        // request
);
    import onoff_regs_pkg::*;
    initial o_req = '0;
    // one command, held over the taking edge, answer seen a cycle later
    task automatic xfer(input logic w, input logic s, input logic [7:0] c,
                        input logic [15:0] d, output logic ok);
        @(negedge i_clk);
        o_req = '{1'b1, w, s, c, s ? ~o_req.wdata : d};
        @(negedge i_clk);
        ok = i_rsp_valid;
        o_req = '{1'b0, ~w, ~s, ~c, ~o_req.wdata};
    endtask
endmodule

/* File: tb/test_onoff_regs.sv */
// testbench: register bank against a reference model
module test_onoff_regs;
    timeunit 1ns;
    timeprecision 1ps;
    import onoff_regs_pkg::*;
    logic        i_clk, i_rstn, pwr, pin, ok, rsp_valid, ack, run;
    logic [15:0] rdata;
    logic [2:0]  vexp;
    logic [11:0] vman;
    logic [7:0]  c;
    action_s     act;
    cmd_req_s    req;
    int          num_errors, comparisons, seed, r, run_r, cfg_r, lock_r, vfmt_r, vset_r;
    logic [7:0]  codes [8] = '{8'h01, 8'h02, 8'h10, 8'h19, 8'h20, 8'h21, 8'hd4, 8'h55};
    logic [7:0]  snd [5] = '{8'h03, 8'h12, 8'h15, 8'h16, 8'h05};
    onoff_regs dut (.i_clk(i_clk), .i_rstn(i_rstn), .i_req(req), .i_power_present(pwr),
        .i_power_supply_on_pin(pin), .o_rsp_valid(rsp_valid), .o_rsp_ack(ack),
        .o_rsp_rdata(rdata), .o_action(act), .o_run(run), .o_vout_exponent(vexp),
        .o_vout_mantissa(vman));
    host_model host (.i_clk(i_clk), .i_rsp_valid(rsp_valid), .o_req(req));
    function automatic int xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic check(input string n, input logic [15:0] e, input logic [15:0] s);
        comparisons++;
        if (s !== e)
        begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", n, e, s);
        end
    endtask
    // strictest lock bit decides
    function automatic bit wr_ok(int a);
        if (lock_r[7]) return a == 'h10;
        if (lock_r[6]) return a inside {'h10, 'h01, 'hd4};
        if (lock_r[5]) return a inside {'h10, 'h01, 'hd4, 'h02, 'h21};
        return 1;
    endfunction
    function automatic int rd_exp(int a);
        case (a)
            'h01: return run_r;
            'h02: return cfg_r;
            'h10: return lock_r;
            'h19: return 'h20;
            'h20: return vfmt_r;
            'h21: return vset_r;
            default: return -1;
        endcase
    endfunction
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        bit e;
        e = wr_ok(a) && rd_exp(a) >= 0 && a != 'h19;
        host.xfer(1'b1, 1'b0, a, d, ok);
        check("write answer", 1, ok);
        check("write ack", e, ack);
        if (e)
            case (a)
                'h01: run_r = d & 'h80 | 'h04;
                'h02: cfg_r = d & 'h1e | 'h01;
                'h10: lock_r = d & 'he0;
                'h20: vfmt_r = d & 'h07;
                'h21: vset_r = d & 'hfff;
            endcase
    endtask
    task automatic rd(input logic [7:0] a);
        int e;
        e = rd_exp(a);
        host.xfer(1'b0, 1'b0, a, 16'h0, ok);
        check("read ack", e >= 0, ack);
        check("read data", e < 0 ? 0 : e, rdata);
    endtask
    task automatic run_chk();
        bit pin_ok, cmd_ok;
        pin_ok = !cfg_r[2] || (pin == cfg_r[1]);
        cmd_ok = !cfg_r[3] || run_r[7];
        check("run", pwr && (cfg_r[4] ? pin_ok && cmd_ok : 1), run);
        check("exponent", vfmt_r[2:0], vexp);
        check("mantissa", vset_r[11:0], vman);
    endtask
    task automatic final_report();
        if (num_errors == 0 && comparisons > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial
    begin
        i_clk = 0;
        forever #20 i_clk = ~i_clk;
    end
    initial
    begin
        i_rstn = 0;
        pwr = 0;
        pin = 0;
        seed = 92;
        run_r = 'h04;
        cfg_r = 'h01;
        lock_r = 0;
        vfmt_r = 0;
        vset_r = 0;
        repeat (16) @(negedge i_clk);
        i_rstn = 1;
        foreach (codes[i]) rd(codes[i]);
        for (int i = 0; i < 5; i++)
        begin
            host.xfer(1'b0, 1'b1, snd[i], 16'h0, ok);
            check("send ack", i < 4, ack);
            check("action", i < 4 ? 4'h8 >> i : 4'h0, act);
        end
        for (int i = 0; i < 300; i++)
        begin
            r = xs();
            pwr = r[0] | r[5];
            pin = r[1];
            c = codes[r[4:2]];
            wr(c, 16'(xs()));
            rd(c);
            run_chk();
        end
        final_report();
    end
endmodule
